// File: rtl/smac_pkg.sv
package smac_pkg;
    // ----------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] A_CMD = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_ATR_LO = 8'h08;
    localparam logic [7:0] A_ATR_HI = 8'h0C;
    localparam logic [7:0] A_PPS = 8'h10;
    localparam logic [7:0] A_FUSE = 8'h14;
    localparam logic [7:0] A_TEAR = 8'h18;
    localparam logic [7:0] A_WCHK = 8'h1C;
    localparam logic [7:0] A_WRES = 8'h20;
    localparam logic [7:0] A_ZKEY = 8'h24;
    localparam logic [7:0] A_ZACC = 8'h28;
    localparam logic [7:0] A_LOCK = 8'h2C;
    // ----------------------------------------
    // counts and limits
    // ----------------------------------------
    localparam logic [8:0] SEL_MIN_CLKS = 9'h190;
    localparam logic [9:0] F_STD = 10'h174;
    localparam logic [9:0] F_ALT = 10'h200;
    localparam logic [2:0] ATTEMPT_LIMIT = 3'h4;
    localparam logic [3:0] CHAR_BITS = 4'hC;
    localparam logic [3:0] AT_MAX_BYTES = 4'h8;
    localparam int PW_SETS = 8;
    localparam int KEY_SETS = 4;
    localparam int ZONES = 16;
    localparam int FUSES = 3;
    localparam logic [31:0] ZKEY_RST = 32'h0000_0000;
    // ----------------------------------------
    // enumerations
    // ----------------------------------------
    typedef enum logic [1:0] {P_WAIT, P_SYNC, P_ASYNC} smac_proto_t;
    typedef enum logic [1:0] {MODE_STD, MODE_AUTH, MODE_ENC} smac_mode_t;
    typedef enum logic [2:0] {OP_NONE, OP_PW, OP_AUTH, OP_ENC, OP_MAC_FAIL} smac_op_t;
endpackage

// File: rtl/smac_sync.sv
`timescale 1ns/1ps
module smac_sync #(
    parameter int W = 3
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    // two stages; the first is read by the second only
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= '0;
            q_o <= '0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule

// File: rtl/smac_top.sv
// Summary of operation
// - three fuses, each freezes configuration permanently
// - async cold reset sends 64-bit answer code
// - async selection sticks until power off
// - accept only listed F and D pairs
// - synchronous interface is the power-up default
// - three security modes: standard, authentication, encryption
// - standard at start; auth, then encryption after
// - anti-tearing: at most eight bytes per write; the code flags a count of eight or more, so seven at most pass
// - anti-tearing: buffer first, copy, recover after loss
// - first byte of each page holds permissions
// - zero permission bit blocks matching page byte
// - permission bit zero locks permission byte itself
// - permission bits only go one to zero
// - locked zone writes only the first byte
// - password stays until power, new password, reset
// - eight password sets, one active, write grants read
// - zone binds to any of four key sets
// - authentication held until power, new try, reset, MAC mismatch
// - four wrong attempts freeze that set
// - password and authentication in any order
// - one async bit lasts one elementary bit time
// - card reset pin pulled up means synchronous
// - MAC mismatch abandons command, returns to standard
`timescale 1ns/1ps
module smac_top #(
    parameter logic [63:0] ATR_RST = 64'h0011_2233_4455_6677 // arbitrary value
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic host_clk_i,
    input wire logic card_rst_i,
    input wire logic io_i,
    output logic io_o,
    output logic io_oe_o,
    input wire logic tear_flag_i
);
    // ----------------------------------------
    // pin sampling
    // ----------------------------------------
    logic [2:0] pins_s;
    logic s_clk, s_rst, s_io, clk_d_r, rst_d_r, clk_rise, rst_rise;

    smac_sync #(.W(3)) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .d_i({io_i, card_rst_i, host_clk_i}),
        .q_o(pins_s)
    );
    assign s_clk = pins_s[0];
    assign s_rst = pins_s[1];
    assign s_io = pins_s[2];

    // edge finders on the already synchronised pins
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_d_r <= 1'b0;
            rst_d_r <= 1'b0;
        end else begin
            clk_d_r <= s_clk;
            rst_d_r <= s_rst;
        end
    end
    assign clk_rise = s_clk & ~clk_d_r;
    assign rst_rise = s_rst & ~rst_d_r;

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    logic acc, wr_en, mapped, cmd_go, wchk_go;
    logic [31:0] rdata_nxt;
    smac_pkg::smac_op_t op;

    assign acc = psel_i & penable_i & ~pready_o;
    // writes land on the edge where pready is seen high
    assign wr_en = psel_i & penable_i & pready_o & pwrite_i & mapped;
    assign mapped = (paddr_i[1:0] == 2'h0) && (paddr_i <= smac_pkg::A_LOCK);
    assign cmd_go = wr_en && paddr_i == smac_pkg::A_CMD;
    assign wchk_go = wr_en && paddr_i == smac_pkg::A_WCHK;
    assign op = smac_pkg::smac_op_t'(pwdata_i[2:0]);

    // one wait state keeps every answer straight from a flop
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else begin
            pready_o <= acc;
            pslverr_o <= acc & ~mapped;
            prdata_o <= (acc & ~pwrite_i & mapped) ? rdata_nxt : 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // protocol selection
    // ----------------------------------------
    smac_pkg::smac_proto_t proto_r;
    logic [8:0] sel_cnt_r;

    // pin reads low for two cycles after reset; a pulled-up pin then wins
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            proto_r <= smac_pkg::P_WAIT;
            sel_cnt_r <= 9'h000;
        end else begin
            unique case (proto_r)
                smac_pkg::P_WAIT: begin
                    if (s_rst) begin
                        proto_r <= (sel_cnt_r >= smac_pkg::SEL_MIN_CLKS) ?
                            smac_pkg::P_ASYNC : smac_pkg::P_SYNC;
                    end else if (clk_rise && sel_cnt_r != smac_pkg::SEL_MIN_CLKS) begin
                        sel_cnt_r <= sel_cnt_r + 9'h001;
                    end
                end
                smac_pkg::P_SYNC: proto_r <= smac_pkg::P_SYNC;
                smac_pkg::P_ASYNC: proto_r <= smac_pkg::P_ASYNC;
            endcase
        end
    end

    // ----------------------------------------
    // answer-to-reset transmitter
    // ----------------------------------------
    logic [63:0] atr_r;
    logic [9:0] etu_r, etu_cnt_r;
    logic atr_busy_r, pps_err_r, tx_bit;
    logic [2:0] atr_byte_r;
    logic [3:0] atr_bit_r;
    logic [7:0] cur_byte;
    logic [2:0] fuse_r;

    assign cur_byte = atr_r[{atr_byte_r, 3'h0} +: 8];
    // start, eight data bits lsb first, even parity, two guard bits
    always_comb begin
        if (atr_bit_r == 4'h0) begin
            tx_bit = 1'b0;
        end else if (atr_bit_r <= 4'h8) begin
            tx_bit = cur_byte[3'(atr_bit_r - 4'h1)];
        end else if (atr_bit_r == 4'h9) begin
            tx_bit = ^cur_byte;
        end else begin
            tx_bit = 1'b1;
        end
    end

    // each bit lasts etu_r rising edges of the host clock
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            atr_busy_r <= 1'b0;
            atr_byte_r <= 3'h0;
            atr_bit_r <= 4'h0;
            etu_cnt_r <= 10'h000;
        end else if (proto_r == smac_pkg::P_SYNC || !s_rst) begin
            atr_busy_r <= 1'b0; // card reset aborts the answer
        // the selecting release starts the answer while proto_r still waits
        end else if (rst_rise && (proto_r == smac_pkg::P_ASYNC
                     || sel_cnt_r >= smac_pkg::SEL_MIN_CLKS)) begin
            atr_busy_r <= 1'b1;
            atr_byte_r <= 3'h0;
            atr_bit_r <= 4'h0;
            etu_cnt_r <= 10'h000;
        end else if (atr_busy_r && clk_rise) begin
            if (etu_cnt_r == etu_r - 10'h001) begin
                etu_cnt_r <= 10'h000;
                if (atr_bit_r == smac_pkg::CHAR_BITS - 4'h1) begin
                    atr_bit_r <= 4'h0;
                    atr_byte_r <= atr_byte_r + 3'h1;
                    atr_busy_r <= (atr_byte_r != 3'h7);
                end else begin
                    atr_bit_r <= atr_bit_r + 4'h1;
                end
            end else begin
                etu_cnt_r <= etu_cnt_r + 10'h001;
            end
        end
    end

    // open drain: only a low is ever driven
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            io_o <= 1'b0;
            io_oe_o <= 1'b0;
        end else begin
            io_o <= 1'b0;
            io_oe_o <= atr_busy_r & ~tx_bit;
        end
    end

    // answer code is programmable until the first fuse is blown
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            atr_r <= ATR_RST;
        end else if (wr_en && !fuse_r[0]) begin
            if (paddr_i == smac_pkg::A_ATR_LO) atr_r[31:0] <= pwdata_i;
            if (paddr_i == smac_pkg::A_ATR_HI) atr_r[63:32] <= pwdata_i;
        end
    end

    // ----------------------------------------
    // speed negotiation and fuses
    // ----------------------------------------
    logic [4:0] pps_d;
    logic pps_f512, pps_ok;
    logic [9:0] pps_etu;

    assign pps_d = pwdata_i[4:0];
    assign pps_f512 = pwdata_i[8];
    // fractional quotients round down to whole host clocks
    always_comb begin
        pps_ok = 1'b1;
        pps_etu = smac_pkg::F_STD;
        unique case ({pps_f512, pps_d})
            6'h01: pps_etu = smac_pkg::F_STD;
            6'h02: pps_etu = smac_pkg::F_STD / 10'h002;
            6'h04: pps_etu = smac_pkg::F_STD / 10'h004;
            6'h08: pps_etu = smac_pkg::F_STD / 10'h008;
            6'h0C: pps_etu = smac_pkg::F_STD / 10'h00C;
            6'h10: pps_etu = smac_pkg::F_STD / 10'h010;
            6'h28: pps_etu = smac_pkg::F_ALT / 10'h008;
            6'h30: pps_etu = smac_pkg::F_ALT / 10'h010;
            default: pps_ok = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            etu_r <= smac_pkg::F_STD;
            pps_err_r <= 1'b0;
        end else if (wr_en && paddr_i == smac_pkg::A_PPS) begin
            if (pps_ok && proto_r == smac_pkg::P_ASYNC && !atr_busy_r) begin
                etu_r <= pps_etu;
                pps_err_r <= 1'b0;
            end else begin
                pps_err_r <= 1'b1;
            end
        end
    end

    // fuses only ever blow; nothing clears them short of power loss
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fuse_r <= 3'h0;
        end else if (wr_en && paddr_i == smac_pkg::A_FUSE) begin
            fuse_r <= fuse_r | pwdata_i[smac_pkg::FUSES-1:0];
        end
    end

    // ----------------------------------------
    // password, authentication and modes
    // ----------------------------------------
    logic sec_clr, pw_valid_r, pw_wr_r, auth_valid_r, pw_lock, key_lock, ok;
    logic [2:0] pw_set_r, set;
    logic [1:0] auth_set_r;
    logic [2:0] pw_att_r [smac_pkg::PW_SETS];
    logic [2:0] key_att_r [smac_pkg::KEY_SETS];
    logic [smac_pkg::PW_SETS-1:0] pw_lk;
    logic [smac_pkg::KEY_SETS-1:0] key_lk;
    smac_pkg::smac_mode_t mode_r;

    assign sec_clr = proto_r != smac_pkg::P_WAIT && !s_rst;
    assign set = pwdata_i[5:3];
    assign ok = pwdata_i[6];
    assign pw_lock = pw_lk[set];
    assign key_lock = key_lk[set[1:0]];

    // failure counters, one per password and key set
    genvar gi;
    generate
        for (gi = 0; gi < smac_pkg::PW_SETS; gi++) begin : g_pw
            assign pw_lk[gi] = pw_att_r[gi] == smac_pkg::ATTEMPT_LIMIT;
            always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    pw_att_r[gi] <= 3'h0;
                end else if (cmd_go && op == smac_pkg::OP_PW && set == gi && !pw_lk[gi]) begin
                    pw_att_r[gi] <= ok ? 3'h0 : pw_att_r[gi] + 3'h1;
                end
            end
        end
        for (gi = 0; gi < smac_pkg::KEY_SETS; gi++) begin : g_key
            assign key_lk[gi] = key_att_r[gi] == smac_pkg::ATTEMPT_LIMIT;
            always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    key_att_r[gi] <= 3'h0;
                end else if (cmd_go && op == smac_pkg::OP_AUTH && set[1:0] == gi
                             && !key_lk[gi]) begin
                    key_att_r[gi] <= ok ? 3'h0 : key_att_r[gi] + 3'h1;
                end
            end
        end
    endgenerate

    // a single active password; its kind says write (which implies read)
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pw_valid_r <= 1'b0;
            pw_set_r <= 3'h0;
            pw_wr_r <= 1'b0;
        end else if (sec_clr) begin
            pw_valid_r <= 1'b0;
        end else if (cmd_go && op == smac_pkg::OP_PW && !pw_lock) begin
            pw_valid_r <= ok;
            pw_set_r <= set;
            pw_wr_r <= pwdata_i[7];
        end
    end

    // only the latest authentication attempt counts
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            auth_valid_r <= 1'b0;
            auth_set_r <= 2'h0;
            mode_r <= smac_pkg::MODE_STD;
        end else if (sec_clr) begin
            auth_valid_r <= 1'b0;
            mode_r <= smac_pkg::MODE_STD;
        end else if (cmd_go) begin
            if (op == smac_pkg::OP_AUTH && !key_lock) begin
                auth_valid_r <= ok;
                auth_set_r <= set[1:0];
                mode_r <= ok ? smac_pkg::MODE_AUTH : smac_pkg::MODE_STD;
            end else if (op == smac_pkg::OP_ENC && ok && auth_valid_r) begin
                mode_r <= smac_pkg::MODE_ENC;
            end else if (op == smac_pkg::OP_MAC_FAIL && mode_r != smac_pkg::MODE_STD) begin
                mode_r <= smac_pkg::MODE_STD;
                auth_valid_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // zone keys, anti-tearing, write checks
    // ----------------------------------------
    logic [31:0] zkey_r, wres_r;
    logic [smac_pkg::ZONES-1:0] zacc;
    logic at_en_r, copy_pend_r, recov_r, boot_r, lock_m, at_bad;
    logic [2:0] woff;
    logic [7:0] perm, wdat;

    // a zone is open when the current key set matches its binding
    generate
        for (gi = 0; gi < smac_pkg::ZONES; gi++) begin : g_zone
            assign zacc[gi] = auth_valid_r && zkey_r[2*gi +: 2] == auth_set_r;
        end
    endgenerate

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            zkey_r <= smac_pkg::ZKEY_RST;
        end else if (wr_en && paddr_i == smac_pkg::A_ZKEY && !fuse_r[1]) begin
            zkey_r <= pwdata_i;
        end
    end

    // tear flag is caught once after release; a set beats a same-write clear
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            boot_r <= 1'b0;
            recov_r <= 1'b0;
            at_en_r <= 1'b0;
            copy_pend_r <= 1'b0;
        end else begin
            boot_r <= 1'b1;
            if (!boot_r) begin
                recov_r <= tear_flag_i;
            end else if (wr_en && paddr_i == smac_pkg::A_TEAR && pwdata_i[3]) begin
                recov_r <= 1'b0;
            end
            if (wr_en && paddr_i == smac_pkg::A_TEAR) begin
                if (!fuse_r[2]) at_en_r <= pwdata_i[0];
                if (pwdata_i[1]) copy_pend_r <= 1'b1;
                else if (pwdata_i[2]) copy_pend_r <= 1'b0;
            end
        end
    end

    assign perm = pwdata_i[7:0];
    assign wdat = pwdata_i[15:8];
    assign woff = pwdata_i[18:16];
    assign lock_m = pwdata_i[19];
    assign at_bad = at_en_r && pwdata_i[23:20] >= smac_pkg::AT_MAX_BYTES;

    // bit n of the page byte guards offset n; offset 0 is the page byte
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wres_r <= 32'h0000_0000;
        end else if (wchk_go) begin
            wres_r[0] <= (!lock_m || perm[woff]) && !at_bad;
            wres_r[15:8] <= (lock_m && woff == 3'h0) ? (perm & wdat) : wdat;
            wres_r[16] <= at_bad;
            wres_r[17] <= lock_m && pwdata_i[23:20] != 4'h0;
        end
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (paddr_i)
            smac_pkg::A_STAT: rdata_nxt = {11'h000, s_io, recov_r, copy_pend_r, at_en_r,
                fuse_r, pps_err_r, atr_busy_r, auth_set_r, auth_valid_r, pw_wr_r,
                pw_set_r, pw_valid_r, mode_r, proto_r};
            smac_pkg::A_ATR_LO: rdata_nxt = atr_r[31:0];
            smac_pkg::A_ATR_HI: rdata_nxt = atr_r[63:32];
            smac_pkg::A_PPS: rdata_nxt = {22'h000000, etu_r};
            smac_pkg::A_FUSE: rdata_nxt = {29'h00000000, fuse_r};
            smac_pkg::A_WRES: rdata_nxt = wres_r;
            smac_pkg::A_ZKEY: rdata_nxt = zkey_r;
            smac_pkg::A_ZACC: rdata_nxt = {16'h0000, zacc};
            smac_pkg::A_LOCK: rdata_nxt = {20'h00000, key_lk, pw_lk};
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_fail_auth;
        cmd_go && op == smac_pkg::OP_AUTH && !ok && !key_lock && !sec_clr;
    endsequence

    a_async_sticky: assert property (proto_r == smac_pkg::P_ASYNC |=>
        proto_r == smac_pkg::P_ASYNC) else $error("async mode left");
    a_sync_default: assert property (proto_r == smac_pkg::P_WAIT && s_rst &&
        sel_cnt_r < smac_pkg::SEL_MIN_CLKS |=> proto_r == smac_pkg::P_SYNC)
        else $error("sync default missed");
    a_atr_start: assert property (proto_r == smac_pkg::P_ASYNC && rst_rise |=>
        atr_busy_r ##2 io_oe_o) else $error("answer code not started");
    a_enc_after_auth: assert property ($rose(mode_r == smac_pkg::MODE_ENC) |->
        $past(auth_valid_r)) else $error("encryption without authentication");
    a_auth_cancel: assert property (s_fail_auth |=> !auth_valid_r &&
        mode_r == smac_pkg::MODE_STD) else $error("failed auth kept state");
    a_pw_frozen: assert property (cmd_go && op == smac_pkg::OP_PW && pw_lock &&
        !sec_clr |=> $stable(pw_valid_r) && $stable(pw_set_r)) else $error("locked set used");
    a_card_clear: assert property (sec_clr |=> !pw_valid_r && !auth_valid_r &&
        mode_r == smac_pkg::MODE_STD) else $error("card reset kept state");
    a_mac_abort: assert property (cmd_go && op == smac_pkg::OP_MAC_FAIL &&
        !sec_clr |=> mode_r == smac_pkg::MODE_STD) else $error("mac failure kept mode");
    a_tear_limit: assert property (wchk_go && at_bad |=> !wres_r[0] && wres_r[16])
        else $error("long anti-tear write allowed");
    a_perm_program: assert property (wchk_go && lock_m && woff == 3'h0 |=>
        (wres_r[15:8] & ~$past(pwdata_i[7:0])) == 8'h00) else $error("permission bit raised");
    a_fuse_hold: assert property (($past(fuse_r) & ~fuse_r) == 3'h0)
        else $error("fuse cleared");
endmodule

// File: tb/smac_host_model.sv
`timescale 1ns/1ps
module smac_host_model (
    input wire logic io_oe_i,
    output logic host_clk_o,
    output logic card_rst_o,
    output logic io_o
);
    logic run = 1'b0;
    // ----------------------------------------
    // reader side: link clock, card reset, io line
    // ----------------------------------------
    // clock parks low outside frames; phase offset keeps it apart from sys_clk
    initial begin
        host_clk_o = 1'b0;
        card_rst_o = 1'b1;
        #7;
        forever begin
            #160;
            if (run || host_clk_o) begin
                host_clk_o = ~host_clk_o;
            end
        end
    end
    // pulled-up open-drain line: high unless the device pulls it low
    assign io_o = ~io_oe_i;
    task automatic set_card(input logic v);
        card_rst_o = v;
    endtask
    task automatic halt();
        run = 1'b0;
    endtask
    // wake-up pulses before the first synchronous command
    task automatic five_pulses();
        run = 1'b1;
        repeat (5) @(posedge host_clk_o);
        run = 1'b0;
    endtask
    // reset held low past 400 rises, clock keeps running for the answer
    task automatic cold_select();
        card_rst_o = 1'b0;
        run = 1'b1;
        repeat (410) @(posedge host_clk_o);
        card_rst_o = 1'b1;
    endtask
endmodule

// File: tb/smac_top_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module smac_top_test;
    logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, tear = 1, err;
    logic [7:0] paddr = 8'h00, pm = 8'hD9;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic hclk, crst, io, io_oe, pready, pslverr, io_drv;
    logic [8:0] pps_w [8] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h00C, 9'h010, 9'h108, 9'h110};
    logic [9:0] etu_x [8] = '{10'h174, 10'h0BA, 10'h05D, 10'h02E, 10'h01F, 10'h017, 10'h040,
        10'h020};
    int bad_count = 0, comparisons = 0, cycles = 0, n;
    always #20 sys_clk = ~sys_clk;
    smac_host_model u_smac_host_model (.io_oe_i(io_oe), .host_clk_o(hclk), .card_rst_o(crst),
        .io_o(io));
    smac_top u_smac_top (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .host_clk_i(hclk),
        .card_rst_i(crst), .io_i(io), .io_o(io_drv), .io_oe_o(io_oe), .tear_flag_i(tear));
    // ----------------------------------------
    // bus tasks and verdict
    // ----------------------------------------
    // apb transfer; request held until the rising edge that samples pready high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic do_reset();
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        tear <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask
    task automatic conclude();
        if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // hang guard, far above the expected 6700 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin bad_count++; conclude(); end
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        do_reset();
        apb(0, smac_pkg::A_STAT, 0);
        `CHK(rd[3:0], 4'h1)
        `CHK(rd[19], 1'b1)
        apb(1, smac_pkg::A_TEAR, 32'h8);
        do apb(0, smac_pkg::A_STAT, 0); while (rd[19] !== 1'b0);
        u_smac_host_model.five_pulses();
        apb(1, smac_pkg::A_CMD, 32'h4A); apb(0, smac_pkg::A_STAT, 0);
        `CHK(rd[11:9], 3'h3)
        `CHK(rd[3:2], 2'h1)
        apb(1, smac_pkg::A_ZKEY, 32'h4); apb(0, smac_pkg::A_ZACC, 0);
        `CHK(rd, 32'h2)
        apb(1, smac_pkg::A_CMD, 32'h4B); apb(0, smac_pkg::A_STAT, 0);
        `CHK(rd[3:2], 2'h2)
        apb(1, smac_pkg::A_CMD, 32'h04); apb(0, smac_pkg::A_STAT, 0);
        `CHK(rd[3:2], 2'h0)
        repeat (4) apb(1, smac_pkg::A_CMD, 32'h12);
        apb(1, smac_pkg::A_CMD, 32'h52); apb(0, smac_pkg::A_STAT, 0);
        `CHK(rd[9], 1'b0)
        repeat (4) apb(1, smac_pkg::A_CMD, 32'h21);
        apb(1, smac_pkg::A_CMD, 32'h61);
        repeat (3) apb(1, smac_pkg::A_CMD, 32'h1A);
        apb(1, smac_pkg::A_CMD, 32'h5A); apb(1, smac_pkg::A_CMD, 32'h1A);
        apb(0, smac_pkg::A_LOCK, 0);
        `CHK(rd[11:0], 12'h410)
        apb(1, smac_pkg::A_CMD, 32'hD9); apb(0, smac_pkg::A_STAT, 0);
        `CHK(rd[8:4], 5'h17)
        for (n = 0; n < 8; n++) begin
            apb(1, smac_pkg::A_WCHK, {13'h0001, n[2:0], 8'hFF, pm}); apb(0, smac_pkg::A_WRES, 0);
            `CHK(rd[0], pm[n])
            if (n == 0) `CHK(rd[15:8], pm)
        end
        apb(1, smac_pkg::A_WCHK, 32'h0008_FFD8); apb(0, smac_pkg::A_WRES, 0);
        `CHK(rd[0], 1'b0)
        apb(1, smac_pkg::A_WCHK, 32'h0038_11FF); apb(0, smac_pkg::A_WRES, 0);
        `CHK(rd[17], 1'b1)
        apb(1, smac_pkg::A_TEAR, 32'h1);
        for (n = 7; n < 9; n++) begin
            apb(1, smac_pkg::A_WCHK, {8'h00, n[3:0], 20'h011FF}); apb(0, smac_pkg::A_WRES, 0);
            `CHK(rd[16], n == 8)
        end
        apb(1, smac_pkg::A_ATR_LO, 32'hA5); apb(1, smac_pkg::A_FUSE, 32'h1);
        apb(1, smac_pkg::A_ATR_LO, 32'hFFFF_FFFF); apb(0, smac_pkg::A_ATR_LO, 0);
        `CHK(rd, 32'hA5)
        apb(0, 8'h30, 0);
        `CHK({err, rd}, 33'h1_0000_0000)
        u_smac_host_model.set_card(1'b0);
        do_reset();
        u_smac_host_model.cold_select();
        n = 0;
        while (io_oe !== 1'b1 && n < 2000) begin @(posedge sys_clk); n++; end
        n = 0;
        while (io_oe === 1'b1 && n < 1000) begin
            @(posedge hclk or negedge io_oe);
            if (io_oe === 1'b1) n++;
        end
        `CHK(n > 370 && n < 374, 1'b1)
        `CHK(io_drv, 1'b0)
        apb(1, smac_pkg::A_CMD, 32'hD9);
        u_smac_host_model.set_card(1'b0);
        u_smac_host_model.halt();
        repeat (4) @(posedge sys_clk);
        apb(0, smac_pkg::A_STAT, 0);
        `CHK(rd[4], 1'b0)
        for (n = 0; n < 9; n++) begin
            apb(1, smac_pkg::A_PPS, {23'h0, n < 8 ? pps_w[n] : 9'h003});
            apb(0, smac_pkg::A_PPS, 0);
            `CHK(rd[9:0], etu_x[n < 8 ? n : 7])
        end
        apb(0, smac_pkg::A_STAT, 0);
        `CHK(rd[13], 1'b1)
        u_smac_host_model.set_card(1'b1);
        apb(0, smac_pkg::A_STAT, 0);
        `CHK(rd[1:0], 2'h2)
        conclude();
    end
endmodule
